// File: verilog/paired_timer_pkg.sv
// constants shared by the paired 16/32-bit timer: control field positions,
// register selects, reset values and prescaler terminal counts.
// assumes a single 10 MHz instruction-cycle clock, sys_clk.
`default_nettype none

package paired_timer_pkg;
  // control register field positions
  localparam int CTRL_ON_BIT = 15;
  localparam int CTRL_IDLE_STOP_BIT = 13;
  localparam int CTRL_GATE_BIT = 6;
  localparam int CTRL_PRE_HI_BIT = 5;
  localparam int CTRL_PRE_LO_BIT = 4;
  localparam int CTRL_PAIR_BIT = 3;
  localparam int CTRL_CLKSRC_BIT = 1;
  localparam logic [15:0] LOWER_CTRL_MASK = 16'hA07A;
  localparam logic [15:0] UPPER_CTRL_MASK = 16'hA072;

  // register selects on the access port
  localparam logic [2:0] SEL_LOWER_COUNT = 3'h0;
  localparam logic [2:0] SEL_HOLDING = 3'h1;
  localparam logic [2:0] SEL_UPPER_COUNT = 3'h2;
  localparam logic [2:0] SEL_PERIOD_LOW = 3'h3;
  localparam logic [2:0] SEL_PERIOD_HIGH = 3'h4;
  localparam logic [2:0] SEL_LOWER_CTRL = 3'h5;
  localparam logic [2:0] SEL_UPPER_CTRL = 3'h6;

  // values after reset
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // prescaler terminal counts, one less than the ratio
  localparam logic [7:0] PRE_TC_DIV1 = 8'h00;
  localparam logic [7:0] PRE_TC_DIV8 = 8'h07;
  localparam logic [7:0] PRE_TC_DIV64 = 8'h3F;
  localparam logic [7:0] PRE_TC_DIV256 = 8'hFF;
endpackage

`default_nettype wire

// File: verilog/pin_sync.sv
// two-flop synchroniser for an external pin with edge detection.
// assumes the pin is asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // first flop feeds only the second; edges come from the settled copy
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule // pin_sync

`default_nettype wire

// File: verilog/timer_prescaler.sv
// selectable 1/8/64/256 prescaler producing one-cycle count enables.
// assumes tickIn, run and clear come from logic on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module timer_prescaler #(
  parameter bit SYNC_OUT = 1'b0
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic tickIn,
  input wire logic run,
  input wire logic clear,
  input wire logic [1:0] sel,
  output logic tickOut
);
  logic [7:0] cnt_q;
  logic [7:0] termCount;
  logic rawTick;

  // code to ratio mapping
  always_comb begin
    unique case (sel)
      2'b00: termCount = paired_timer_pkg::PRE_TC_DIV1;
      2'b01: termCount = paired_timer_pkg::PRE_TC_DIV8;
      2'b10: termCount = paired_timer_pkg::PRE_TC_DIV64;
      2'b11: termCount = paired_timer_pkg::PRE_TC_DIV256;
    endcase
  end

  assign rawTick = tickIn && run && (cnt_q >= termCount);

  // a halted prescaler cannot be cleared, clear is qualified by run
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 8'h00;
    end else if (run && clear) begin
      cnt_q <= 8'h00;
    end else if (tickIn && run) begin
      cnt_q <= rawTick ? 8'h00 : cnt_q + 8'h01;
    end
  end

  // optional retiming costs one cycle of latency but gives a clean enable
  generate
    if (SYNC_OUT) begin : g_sync
      logic tick_q;
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          tick_q <= 1'b0;
        end else begin
          tick_q <= rawTick && !clear;
        end
      end
      assign tickOut = tick_q;
    end else begin : g_direct
      assign tickOut = rawTick;
    end
  endgenerate
endmodule // timer_prescaler

`default_nettype wire

// File: verilog/paired_timer.sv
// timer pair: two 16-bit timers or one 32-bit timer/counter with
// holding register, gated accumulation, prescalers and converter trigger.
// assumes software access through the wrEn/rdEn strobe port on sys_clk;
// the external clock pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none

module paired_timer (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cpuIdle,
  input wire logic cpuSleep,
  input wire logic lowerExtClockPin,
  input wire logic upperExtClockPin,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [2:0] regSel,
  input wire logic [15:0] wrData,
  input wire logic lowerIntEnable,
  input wire logic upperIntEnable,
  input wire logic lowerIntFlagClear,
  input wire logic upperIntFlagClear,
  output logic [15:0] rdData_q,
  output logic lowerIntFlag_q,
  output logic upperIntFlag_q,
  output logic lowerIrq_q,
  output logic upperIrq_q,
  output logic adcTrigger_q
);
  logic [15:0] lowerCount_q;
  logic [15:0] upperCount_q;
  logic [15:0] holding_q;
  logic [15:0] periodLow_q;
  logic [15:0] periodHigh_q;
  logic [15:0] lowerCtrl_q;
  logic [15:0] upperCtrl_q;

  logic lowerLevel, lowerRise, lowerFall;
  logic upperRise;
  logic pairMode, lowerRun, upperRun, lowerGated;
  logic lowerSrcTick, upperSrcTick, lowerInc, upperInc;
  logic lowerPreClear, upperPreClear;
  logic wrLowerCount, wrUpperCount, wrLowerCtrl, wrUpperCtrl;
  logic [31:0] count32, period32, next32;
  logic match32, matchLow, matchHigh;
  logic lowerSet, upperSet, adcSet;

  pin_sync u_lower_pin (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pinIn(lowerExtClockPin),
    .level(lowerLevel),
    .rise(lowerRise),
    .fall(lowerFall)
  );

  pin_sync u_upper_pin (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pinIn(upperExtClockPin),
    // upper gate is ignored, so its settled level is left open
    .level(),
    .rise(upperRise),
    .fall()
  );

  // access strobes
  assign wrLowerCount = wrEn && (regSel == paired_timer_pkg::SEL_LOWER_COUNT);
  assign wrUpperCount = wrEn && (regSel == paired_timer_pkg::SEL_UPPER_COUNT);
  assign wrLowerCtrl = wrEn && (regSel == paired_timer_pkg::SEL_LOWER_CTRL);
  assign wrUpperCtrl = wrEn && (regSel == paired_timer_pkg::SEL_UPPER_CTRL);

  // pairing bit lives in the lower control register only
  assign pairMode = lowerCtrl_q[paired_timer_pkg::CTRL_PAIR_BIT];

  // sleep stops both halves; idle stops them only if asked
  assign lowerRun = lowerCtrl_q[paired_timer_pkg::CTRL_ON_BIT] && !cpuSleep
    && !(cpuIdle && lowerCtrl_q[paired_timer_pkg::CTRL_IDLE_STOP_BIT]);
  assign upperRun = !pairMode && upperCtrl_q[paired_timer_pkg::CTRL_ON_BIT] && !cpuSleep
    && !(cpuIdle && upperCtrl_q[paired_timer_pkg::CTRL_IDLE_STOP_BIT]);

  // gate only counts with internal clock selected
  assign lowerGated = lowerCtrl_q[paired_timer_pkg::CTRL_GATE_BIT]
    && !lowerCtrl_q[paired_timer_pkg::CTRL_CLKSRC_BIT];

  // source selection: external edge or instruction cycle, no asynchronous mode
  always_comb begin
    if (lowerCtrl_q[paired_timer_pkg::CTRL_CLKSRC_BIT]) begin
      lowerSrcTick = lowerRise;
    end else if (lowerGated) begin
      lowerSrcTick = lowerLevel;
    end else begin
      lowerSrcTick = 1'b1;
    end
  end

  // upper gate bit is ignored, so the upper half never accumulates
  assign upperSrcTick = upperCtrl_q[paired_timer_pkg::CTRL_CLKSRC_BIT] ? upperRise : 1'b1;

  // a count or control write resets that half's prescaler while that half is running
  assign lowerPreClear = wrLowerCount || wrLowerCtrl || (pairMode && (wrUpperCount || wrUpperCtrl));
  assign upperPreClear = wrUpperCount || wrUpperCtrl;

  // lower prescaler is retimed, upper is not
  timer_prescaler #(
    .SYNC_OUT(1'b1)
  ) u_lower_pre (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .tickIn(lowerSrcTick),
    .run(lowerRun),
    .clear(lowerPreClear),
    .sel(lowerCtrl_q[paired_timer_pkg::CTRL_PRE_HI_BIT:paired_timer_pkg::CTRL_PRE_LO_BIT]),
    .tickOut(lowerInc)
  );

  // in 32-bit mode upperRun is low, so this prescaler sits idle
  timer_prescaler #(
    .SYNC_OUT(1'b0)
  ) u_upper_pre (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .tickIn(upperSrcTick),
    .run(upperRun),
    .clear(upperPreClear),
    .sel(upperCtrl_q[paired_timer_pkg::CTRL_PRE_HI_BIT:paired_timer_pkg::CTRL_PRE_LO_BIT]),
    .tickOut(upperInc)
  );

  // combined count and period, lower word least significant
  assign count32 = {upperCount_q, lowerCount_q};
  assign period32 = {periodHigh_q, periodLow_q};
  assign match32 = (count32 == period32);
  assign next32 = match32 ? 32'h0000_0000 : count32 + 32'h0000_0001;
  assign matchLow = (lowerCount_q == periodLow_q);
  assign matchHigh = (upperCount_q == periodHigh_q);

  // lower count: software write beats counting
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lowerCount_q <= paired_timer_pkg::COUNT_RESET;
    end else if (wrLowerCount) begin
      lowerCount_q <= wrData;
    end else if (lowerInc && pairMode) begin
      lowerCount_q <= next32[15:0];
    end else if (lowerInc) begin
      lowerCount_q <= matchLow ? 16'h0000 : lowerCount_q + 16'h0001;
    end
  end

  // upper count: loaded from holding on a paired lower write
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      upperCount_q <= paired_timer_pkg::COUNT_RESET;
    end else if (wrUpperCount) begin
      upperCount_q <= wrData;
    end else if (wrLowerCount && pairMode) begin
      upperCount_q <= holding_q;
    end else if (lowerInc && pairMode) begin
      upperCount_q <= next32[31:16];
    end else if (upperInc) begin
      upperCount_q <= matchHigh ? 16'h0000 : upperCount_q + 16'h0001;
    end
  end

  // holding register: lower read snapshots the upper word
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      holding_q <= paired_timer_pkg::COUNT_RESET;
    end else if (wrEn && regSel == paired_timer_pkg::SEL_HOLDING) begin
      holding_q <= wrData;
    end else if (rdEn && regSel == paired_timer_pkg::SEL_LOWER_COUNT) begin
      holding_q <= upperCount_q;
    end
  end

  // period and control registers; control write does not touch counts
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      periodLow_q <= paired_timer_pkg::PERIOD_RESET;
      periodHigh_q <= paired_timer_pkg::PERIOD_RESET;
      lowerCtrl_q <= paired_timer_pkg::CTRL_RESET;
      upperCtrl_q <= paired_timer_pkg::CTRL_RESET;
    end else if (wrEn) begin
      if (regSel == paired_timer_pkg::SEL_PERIOD_LOW) begin
        periodLow_q <= wrData;
      end
      if (regSel == paired_timer_pkg::SEL_PERIOD_HIGH) begin
        periodHigh_q <= wrData;
      end
      if (wrLowerCtrl) begin
        lowerCtrl_q <= wrData & paired_timer_pkg::LOWER_CTRL_MASK;
      end
      if (wrUpperCtrl) begin
        upperCtrl_q <= wrData & paired_timer_pkg::UPPER_CTRL_MASK;
      end
    end
  end

  // registered read data; unused selects read zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdData_q <= 16'h0000;
    end else if (rdEn) begin
      unique case (regSel)
        paired_timer_pkg::SEL_LOWER_COUNT: rdData_q <= lowerCount_q;
        paired_timer_pkg::SEL_HOLDING: rdData_q <= holding_q;
        paired_timer_pkg::SEL_UPPER_COUNT: rdData_q <= upperCount_q;
        paired_timer_pkg::SEL_PERIOD_LOW: rdData_q <= periodLow_q;
        paired_timer_pkg::SEL_PERIOD_HIGH: rdData_q <= periodHigh_q;
        paired_timer_pkg::SEL_LOWER_CTRL: rdData_q <= lowerCtrl_q;
        paired_timer_pkg::SEL_UPPER_CTRL: rdData_q <= upperCtrl_q;
        default: rdData_q <= 16'h0000;
      endcase
    end
  end

  // interrupt events; gate fall ends accumulation but keeps the count
  assign lowerSet = !pairMode && ((lowerInc && matchLow)
    || (lowerGated && lowerRun && lowerFall));
  assign upperSet = pairMode ? ((lowerInc && match32) || (lowerGated && lowerRun && lowerFall))
    : (upperInc && matchHigh);
  assign adcSet = pairMode && lowerInc && match32;

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lowerIntFlag_q <= 1'b0;
      upperIntFlag_q <= 1'b0;
    end else begin
      lowerIntFlag_q <= lowerSet || (lowerIntFlag_q && !lowerIntFlagClear);
      upperIntFlag_q <= upperSet || (upperIntFlag_q && !upperIntFlagClear);
    end
  end

  // requests gated by the enables; one cycle behind the flag
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lowerIrq_q <= 1'b0;
      upperIrq_q <= 1'b0;
      adcTrigger_q <= 1'b0;
    end else begin
      lowerIrq_q <= lowerIntFlag_q && lowerIntEnable;
      upperIrq_q <= upperIntFlag_q && upperIntEnable;
      adcTrigger_q <= adcSet;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence wrap32_s;
    pairMode && lowerInc && match32 && !wrEn;
  endsequence

  sequence coherent_wr_s;
    wrLowerCount && pairMode && !wrUpperCount;
  endsequence

  holding_capture_a: assert property (
    rdEn && regSel == paired_timer_pkg::SEL_LOWER_COUNT && !wrEn |=> holding_q == $past(upperCount_q))
    else $error("holding register missed upper word");

  coherent_write_a: assert property (
    coherent_wr_s |=> upperCount_q == $past(holding_q) && lowerCount_q == $past(wrData))
    else $error("paired write not coherent");

  wrap_trigger_a: assert property (
    wrap32_s |=> count32 == 32'h0000_0000 && adcTrigger_q && upperIntFlag_q)
    else $error("32-bit wrap or trigger wrong");

  count32_step_a: assert property (
    pairMode && lowerInc && !match32 && !wrEn |=> count32 == $past(count32) + 32'h0000_0001)
    else $error("32-bit count did not step by one");

  ctrl_keeps_count_a: assert property (
    wrLowerCtrl && !lowerInc |=> lowerCount_q == $past(lowerCount_q))
    else $error("control write changed count");

  sleep_no_count_a: assert property (
    cpuSleep[*2] ##0 !wrEn |=> $stable(lowerCount_q))
    else $error("counted during sleep");

  flag_set_wins_a: assert property (
    upperSet && upperIntFlagClear |=> upperIntFlag_q)
    else $error("flag set lost to clear");

  irq_enable_gate_a: assert property (
    !upperIntEnable |=> !upperIrq_q)
    else $error("request without enable");

  paired_no_lower_flag_a: assert property (
    pairMode && !lowerIntFlag_q |=> !lowerIntFlag_q)
    else $error("lower flag set in 32-bit mode");

  split_no_trigger_a: assert property (
    !pairMode |=> !adcTrigger_q)
    else $error("converter trigger outside 32-bit mode");

  // retimed enable lags the gate by one cycle, so two closed cycles are needed
  sequence gate_closed_s;
    lowerGated && !lowerLevel;
  endsequence

  gate_closed_hold_a: assert property (
    gate_closed_s ##1 gate_closed_s ##0 !wrEn |=> $stable(lowerCount_q))
    else $error("counted with gate low");
endmodule // paired_timer

`default_nettype wire

// File: dv/ext_clock_model.sv
// partner model of the source on the external clock / gate pins.
// assumes sys_clk is the instruction clock; pin moves 13 ns after its falls.
`timescale 1ns/1ps
`default_nettype none

module ext_clock_model (
  input wire logic sys_clk,
  output logic pin
);
  // the source is not free running, so the pin rests low between bursts
  initial pin = 1'b0;

  // burst of n rising edges, each level held halfCyc cycles
  task automatic pulses(input int n, input int halfCyc);
    repeat (n) begin
      #13 pin = 1'b1;
      repeat (halfCyc) @(negedge sys_clk);
      #13 pin = 1'b0;
      repeat (halfCyc) @(negedge sys_clk);
    end
  endtask

  // one gate window of len whole cycles, then the falling edge
  task automatic gate(input int len);
    #13 pin = 1'b1;
    repeat (len) @(negedge sys_clk);
    #13 pin = 1'b0;
  endtask
endmodule // ext_clock_model

`default_nettype wire

// File: dv/paired_timer_test.sv
// self-checking bench for the paired timer: register table, then holding,
// counting, idle/sleep, external clock and gate cases.
// assumes the partner model drives both external clock pins.
`timescale 1ns/1ps
`default_nettype none

module paired_timer_test;
  typedef struct {logic [2:0] sel; logic [15:0] data; logic [15:0] expv;} row_t;
  logic sys_clk, resetn, cpuIdle, cpuSleep, extPin, wrEn, rdEn;
  logic upperIntEnable, upperIntFlagClear, lowerIntFlag, upperIntFlag, lowerIrq, upperIrq, adcTrigger;
  logic [2:0] regSel;
  logic [15:0] wrData, rdData, a, b;
  int n_fail = 0;
  int num_checks = 0;
  int t;
  int ratio[4] = '{1, 8, 64, 256};
  row_t rows[6];

  paired_timer u_paired_timer (.sys_clk(sys_clk), .resetn(resetn), .cpuIdle(cpuIdle),
    .cpuSleep(cpuSleep), .lowerExtClockPin(extPin), .upperExtClockPin(extPin), .wrEn(wrEn),
    .rdEn(rdEn), .regSel(regSel), .wrData(wrData), .lowerIntEnable(1'b1),
    .upperIntEnable(upperIntEnable), .lowerIntFlagClear(1'b0), .upperIntFlagClear(upperIntFlagClear),
    .rdData_q(rdData), .lowerIntFlag_q(lowerIntFlag), .upperIntFlag_q(upperIntFlag),
    .lowerIrq_q(lowerIrq), .upperIrq_q(upperIrq), .adcTrigger_q(adcTrigger));

  ext_clock_model u_ext_clock_model (.sys_clk(sys_clk), .pin(extPin));

  // 100 ns instruction clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chkWord(input string what, input logic [15:0] expv, input logic [15:0] got);
    num_checks++;
    if (got !== expv) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, expv, got);
    end
  endtask

  task automatic chkBit(input string what, input logic expv, input logic got);
    num_checks++;
    if (got !== expv) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", what, expv, got);
    end
  endtask

  // strobes last one cycle; a gap cycle keeps calls from colliding
  task automatic wr(input logic [2:0] sel, input logic [15:0] d);
    @(negedge sys_clk);
    wrEn = 1'b1;
    regSel = sel;
    wrData = d;
    @(negedge sys_clk);
    wrEn = 1'b0;
  endtask

  task automatic rd(input logic [2:0] sel, output logic [15:0] v);
    @(negedge sys_clk);
    rdEn = 1'b1;
    regSel = sel;
    @(negedge sys_clk);
    rdEn = 1'b0;
    v = rdData;
  endtask

  // counts cycles up to the next trigger pulse, bounded
  task automatic waitTrig(output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (adcTrigger !== 1'b1 && n < 2000);
    chkBit("trigger", 1'b1, adcTrigger);
  endtask

  task automatic pulseClear;
    @(negedge sys_clk);
    upperIntFlagClear = 1'b1;
    @(negedge sys_clk);
    upperIntFlagClear = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // the whole run needs about 1650 cycles
  initial begin
    repeat (8000) @(posedge sys_clk);
    n_fail++;
    $display("mismatch watchdog expected done seen timeout");
    stop_test;
  end

  initial begin
    resetn = 1'b0;
    cpuIdle = 1'b0;
    cpuSleep = 1'b0;
    wrEn = 1'b0;
    rdEn = 1'b0;
    regSel = 3'h0;
    wrData = 16'h0000;
    upperIntEnable = 1'b1;
    upperIntFlagClear = 1'b0;
    rows = '{'{paired_timer_pkg::SEL_PERIOD_LOW, 16'h1234, 16'h1234},
      '{paired_timer_pkg::SEL_PERIOD_HIGH, 16'hABCD, 16'hABCD},
      '{paired_timer_pkg::SEL_LOWER_CTRL, 16'h7FFF, 16'h207A},
      '{paired_timer_pkg::SEL_UPPER_CTRL, 16'h7FFF, 16'h2072},
      '{paired_timer_pkg::SEL_UPPER_COUNT, 16'h5A5A, 16'h5A5A},
      '{3'h7, 16'hFFFF, 16'h0000}};
    repeat (3) @(negedge sys_clk);
    chkWord("rdData", 16'h0000, rdData);
    chkBit("upperIntFlag", 1'b0, upperIntFlag);
    resetn = 1'b1;
    rd(paired_timer_pkg::SEL_PERIOD_LOW, a);
    chkWord("periodLow", 16'hFFFF, a);
    $display("test reset done");
    // ordinary accesses: write, read back, compare
    foreach (rows[i]) begin
      wr(rows[i].sel, rows[i].data);
      rd(rows[i].sel, a);
      chkWord("register", rows[i].expv, a);
    end
    $display("test table done");
    // coherent 32-bit write and read with the timer stopped
    wr(paired_timer_pkg::SEL_LOWER_CTRL, 16'h0008);
    wr(paired_timer_pkg::SEL_HOLDING, 16'hABCD);
    wr(paired_timer_pkg::SEL_LOWER_COUNT, 16'h1234);
    wr(paired_timer_pkg::SEL_HOLDING, 16'h5555);
    wr(paired_timer_pkg::SEL_LOWER_CTRL, 16'h0008);
    rd(paired_timer_pkg::SEL_LOWER_COUNT, a);
    chkWord("lowerCount", 16'h1234, a);
    rd(paired_timer_pkg::SEL_HOLDING, a);
    chkWord("holding", 16'hABCD, a);
    rd(paired_timer_pkg::SEL_UPPER_COUNT, a);
    chkWord("upperCount", 16'hABCD, a);
    $display("test holding done");
    // period 1: trigger gap is two prescaled ticks; upper prescale left at 256
    wr(paired_timer_pkg::SEL_PERIOD_HIGH, 16'h0000);
    wr(paired_timer_pkg::SEL_PERIOD_LOW, 16'h0001);
    wr(paired_timer_pkg::SEL_HOLDING, 16'h0000);
    wr(paired_timer_pkg::SEL_LOWER_COUNT, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wr(paired_timer_pkg::SEL_LOWER_CTRL, 16'h8008 | 16'(c << 4));
      waitTrig(t);
      waitTrig(t);
      chkWord("trigGap", 16'(2 * ratio[c]), 16'(t));
    end
    repeat (2) @(negedge sys_clk);
    chkBit("upperIntFlag", 1'b1, upperIntFlag);
    chkBit("lowerIntFlag", 1'b0, lowerIntFlag);
    chkBit("upperIrq", 1'b1, upperIrq);
    wr(paired_timer_pkg::SEL_LOWER_CTRL, 16'h0008);
    pulseClear;
    chkBit("upperIntFlag", 1'b0, upperIntFlag);
    chkBit("upperIrq", 1'b0, upperIrq);
    $display("test prescale done");
    // carry from the lower word into the upper one, then wrap to zero
    wr(paired_timer_pkg::SEL_PERIOD_HIGH, 16'h0001);
    wr(paired_timer_pkg::SEL_PERIOD_LOW, 16'h0000);
    wr(paired_timer_pkg::SEL_LOWER_COUNT, 16'hFFF0);
    wr(paired_timer_pkg::SEL_LOWER_CTRL, 16'h8008);
    waitTrig(t);
    rd(paired_timer_pkg::SEL_LOWER_COUNT, a);
    rd(paired_timer_pkg::SEL_HOLDING, a);
    chkWord("upperAfterWrap", 16'h0000, a);
    $display("test wrap done");
    // idle with and without the stop bit, and sleep
    wr(paired_timer_pkg::SEL_PERIOD_HIGH, 16'hFFFF);
    wr(paired_timer_pkg::SEL_PERIOD_LOW, 16'hFFFF);
    for (int m = 0; m < 4; m++) begin
      wr(paired_timer_pkg::SEL_LOWER_CTRL, m == 0 ? 16'hA008 : 16'h8008);
      cpuIdle = (m == 0 || m == 2);
      cpuSleep = (m == 1);
      rd(paired_timer_pkg::SEL_LOWER_COUNT, a);
      repeat (10) @(negedge sys_clk);
      rd(paired_timer_pkg::SEL_LOWER_COUNT, b);
      chkWord("idleAdvance", m < 2 ? 16'h0000 : 16'h000C, b - a);
    end
    cpuIdle = 1'b0;
    $display("test idle done");
    // external clock: five synchronised rising edges
    wr(paired_timer_pkg::SEL_LOWER_CTRL, 16'h800A);
    wr(paired_timer_pkg::SEL_HOLDING, 16'h0000);
    wr(paired_timer_pkg::SEL_LOWER_COUNT, 16'h0000);
    u_ext_clock_model.pulses(5, 3);
    repeat (8) @(negedge sys_clk);
    rd(paired_timer_pkg::SEL_LOWER_COUNT, a);
    chkWord("extEdges", 16'h0005, a);
    $display("test counter done");
    // gate window of 20 cycles, interrupt masked
    wr(paired_timer_pkg::SEL_LOWER_CTRL, 16'h8048);
    wr(paired_timer_pkg::SEL_LOWER_COUNT, 16'h0000);
    upperIntEnable = 1'b0;
    pulseClear;
    u_ext_clock_model.gate(20);
    repeat (8) @(negedge sys_clk);
    rd(paired_timer_pkg::SEL_LOWER_COUNT, a);
    chkWord("gateCount", 16'h0014, a);
    chkBit("upperIntFlag", 1'b1, upperIntFlag);
    chkBit("upperIrq", 1'b0, upperIrq);
    repeat (20) @(negedge sys_clk);
    rd(paired_timer_pkg::SEL_LOWER_COUNT, a);
    chkWord("gateKept", 16'h0014, a);
    $display("test gate done");
    // 16-bit mode: lower half wraps on its own period
    wr(paired_timer_pkg::SEL_LOWER_CTRL, 16'h8000);
    wr(paired_timer_pkg::SEL_PERIOD_LOW, 16'h0003);
    wr(paired_timer_pkg::SEL_LOWER_COUNT, 16'h0000);
    repeat (10) @(negedge sys_clk);
    chkBit("lowerIntFlag", 1'b1, lowerIntFlag);
    chkBit("lowerIrq", 1'b1, lowerIrq);
    // upper half as its own synchronous counter, period 2, four edges
    wr(paired_timer_pkg::SEL_UPPER_CTRL, 16'h8002);
    wr(paired_timer_pkg::SEL_UPPER_COUNT, 16'h0000);
    wr(paired_timer_pkg::SEL_PERIOD_HIGH, 16'h0002);
    pulseClear;
    chkBit("upperIntFlag", 1'b0, upperIntFlag);
    u_ext_clock_model.pulses(4, 3);
    repeat (8) @(negedge sys_clk);
    rd(paired_timer_pkg::SEL_UPPER_COUNT, a);
    chkWord("upperEdges", 16'h0001, a);
    chkBit("upperIntFlag", 1'b1, upperIntFlag);
    $display("test split done");
    // second reset in mid-run
    resetn = 1'b0;
    @(negedge sys_clk);
    chkBit("lowerIntFlag", 1'b0, lowerIntFlag);
    resetn = 1'b1;
    rd(paired_timer_pkg::SEL_LOWER_CTRL, a);
    chkWord("lowerCtrl", 16'h0000, a);
    $display("test reset again done");
    stop_test;
  end
endmodule // paired_timer_test

`default_nettype wire
